/* core/tpd_core.v */
// Logic interface of a three-phase FET pre-driver
// Behaviour
// - Gates may turn on only when both enables high
// - Either enable low forces all gates off
// - Enable off-forcing acts without clock
// - High side waits for its low-side pulse
// - Reset low disables outputs, resets logic fast
// - Power-on reset tristates drivers, ignores serial
// - Phase status low below half supply
// - High-side inputs active low, default off
// - Low-side inputs active high, default off
// - Interrupt held high until clear command
// - Two mask registers gate fault interrupts
// - Serial commands framed by chip select low
// - Serial input sampled on falling clock, MSB first
// - Serial output driven only during chip select
// - Serial output changes on rising clock
// - Over-current flag high during over-current
// - Deadtime and interlock, both defeatable
// - Mode set only by serial commands
// - Deadtime 1 to 255 periods, saturating, zero allowed
`timescale 1ns/10ps
`include "tpd_defs.vh"
module tpd_core #(
  parameter DT_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  input wire power_good,
  // Enables
  input wire enable_one,
  input wire enable_two,
  // Phase commands
  input wire phase_a_high_in_n,
  input wire phase_a_low_in,
  input wire phase_b_high_in_n,
  input wire phase_b_low_in,
  input wire phase_c_high_in_n,
  input wire phase_c_low_in,
  // Analog comparator results
  input wire [2:0] phase_above_half,
  input wire overcurrent_det,
  input wire [7:0] fault_det,
  // Serial port
  input wire serial_cs_n,
  input wire serial_clk,
  input wire serial_in,
  output reg serial_out,
  output wire serial_out_en,
  // Gate drives
  output wire [2:0] high_side_gate,
  output wire [2:0] low_side_gate,
  output wire gate_drive_en,
  // Status
  output wire phase_a_compare_out,
  output wire phase_b_compare_out,
  output wire phase_c_compare_out,
  output reg overcurrent_flag_out,
  output reg interrupt_out
);

  ////////////////////////////////////////////////////////////////////
  // Reset combination

  // Power-on and pin reset both clear logic; reset is synchronous,
  // so the 77 ns bound holds only because one 40 ns period is shorter
  wire logic_rst_n = reset_n && power_good;

  ////////////////////////////////////////////////////////////////////
  // Synchronisers

  wire [2:0] high_n_sync;
  wire [2:0] low_sync;
  wire [1:0] en_sync;
  wire [2:0] ser_sync;
  wire [2:0] cmp_sync;
  wire [8:0] flt_sync;

  tpd_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_high (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in({phase_c_high_in_n, phase_b_high_in_n, phase_a_high_in_n}),
    .sync_out(high_n_sync)
  );

  tpd_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_low (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in({phase_c_low_in, phase_b_low_in, phase_a_low_in}),
    .sync_out(low_sync)
  );

  tpd_sync #(.WIDTH(2), .INIT(2'h0)) u_sync_en (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in({enable_two, enable_one}),
    .sync_out(en_sync)
  );

  // Chip select resets to idle high
  tpd_sync #(.WIDTH(3), .INIT(3'h4)) u_sync_ser (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in({serial_cs_n, serial_clk, serial_in}),
    .sync_out(ser_sync)
  );

  tpd_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_cmp (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in(phase_above_half),
    .sync_out(cmp_sync)
  );

  tpd_sync #(.WIDTH(9), .INIT(9'h000)) u_sync_flt (
    .sys_clk(sys_clk),
    .reset_n(logic_rst_n),
    .async_in({overcurrent_det, fault_det}),
    .sync_out(flt_sync)
  );

  wire cs_n_s = ser_sync[2];
  wire sclk_s = ser_sync[1];
  wire sin_s = ser_sync[0];

  ////////////////////////////////////////////////////////////////////
  // Serial port

  reg sclk_prev;
  reg [`TPD_CMD_W-1:0] rx_shift;
  reg [`TPD_CMD_W-1:0] tx_shift;
  reg [2:0] bit_cnt;
  reg [3:0] mask_first;
  reg [3:0] mask_second;
  reg [1:0] mode_bits;
  reg [DT_W-1:0] deadtime;
  reg [3:0] dt_low;
  reg [7:0] fault_latch;
  reg clr_int;

  wire sclk_fall = sclk_prev && !sclk_s;
  wire sclk_rise = !sclk_prev && sclk_s;
  wire cs_act = !cs_n_s;
  wire [7:0] rx_word = {rx_shift[6:0], sin_s};
  wire [3:0] rx_op = rx_word[`TPD_OP_HI:`TPD_OP_LO];
  wire [3:0] rx_dat = rx_word[`TPD_OP_LO-1:0];
  wire [DT_W-1:0] dt_req = {rx_dat, dt_low};

  // Serial output may only drive while powered and selected
  assign serial_out_en = !serial_cs_n && reset_n && power_good;

  always @(posedge sys_clk) begin
    if (!logic_rst_n) begin
      sclk_prev <= 1'b0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      bit_cnt <= 3'h0;
      mask_first <= `TPD_MASK_RST;
      mask_second <= `TPD_MASK_RST;
      mode_bits <= `TPD_MODE_RST;
      deadtime <= `TPD_DT_RST;
      dt_low <= 4'h0;
      clr_int <= 1'b0;
      serial_out <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      clr_int <= 1'b0;
      if (!cs_act) begin
        bit_cnt <= 3'h0;
        tx_shift <= fault_latch;
        serial_out <= 1'b0;
      end else begin
        if (sclk_rise) begin
          serial_out <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
        if (sclk_fall) begin
          rx_shift <= rx_word;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            // Commands are the only way to change configuration
            case (rx_op)
              `TPD_OP_FAULT_MASK_FIRST: mask_first <= rx_dat;
              `TPD_OP_FAULT_MASK_SECOND: mask_second <= rx_dat;
              `TPD_OP_MODE: mode_bits <= rx_dat[1:0];
              `TPD_OP_CLRINT: clr_int <= 1'b1;
              `TPD_OP_DT_LO: dt_low <= rx_dat;
              `TPD_OP_DT_HI: begin
                // A zero request still gives one period; zero needs its own command
                if (dt_req == `TPD_DT_ZERO)
                  deadtime <= 8'h01;
                else
                  deadtime <= dt_req;
              end
              `TPD_OP_DT_ZERO: deadtime <= `TPD_DT_ZERO;
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Faults and interrupt

  wire [7:0] fault_unmasked = flt_sync[7:0] & ~{mask_second, mask_first};

  always @(posedge sys_clk) begin
    if (!logic_rst_n) begin
      fault_latch <= 8'h00;
      interrupt_out <= 1'b0;
      overcurrent_flag_out <= 1'b0;
    end else begin
      overcurrent_flag_out <= flt_sync[8];
      // A new fault in the clear cycle wins over the clear
      if (clr_int)
        fault_latch <= flt_sync[7:0];
      else
        fault_latch <= fault_latch | flt_sync[7:0];
      if (|fault_unmasked)
        interrupt_out <= 1'b1;
      else if (clr_int)
        interrupt_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Phase control

  wire en_sync_both = en_sync[0] && en_sync[1];
  wire [2:0] high_cmd;
  wire [2:0] low_cmd;
  wire [2:0] phase_low_seen;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      tpd_phase #(.DT_W(DT_W)) u_phase (
        .sys_clk(sys_clk),
        .reset_n(logic_rst_n),
        .high_req(!high_n_sync[g]),
        .low_req(low_sync[g]),
        .enabled(en_sync_both),
        .deadtime(deadtime),
        .no_interlock(mode_bits[`TPD_MODE_NOLOCK]),
        .no_deadtime(mode_bits[`TPD_MODE_NODT]),
        .high_drive(high_cmd[g]),
        .low_drive(low_cmd[g]),
        .low_seen(phase_low_seen[g])
      );
    end
  endgenerate

  // Enables gate the outputs directly so dropping one needs no clock edge
  wire en_raw = enable_one && enable_two;
  assign high_side_gate = high_cmd & {3{en_raw && reset_n}};
  assign low_side_gate = low_cmd & {3{en_raw && reset_n}};
  // Drivers are tristated until the supply is good
  assign gate_drive_en = power_good;

  ////////////////////////////////////////////////////////////////////
  // Phase comparators

  assign phase_a_compare_out = cmp_sync[0];
  assign phase_b_compare_out = cmp_sync[1];
  assign phase_c_compare_out = cmp_sync[2];

endmodule // tpd_core

/* inc/tpd_defs.vh */
// Constants of the three-phase pre-driver logic interface
`ifndef TPD_DEFS_VH
`define TPD_DEFS_VH

// Clock and timing
`define TPD_CLK_MHZ 25
`define TPD_RESET_NS 77
`define TPD_RESET_CYC ((`TPD_RESET_NS * `TPD_CLK_MHZ) / 1000)

// Deadtime limits, in time-base periods
`define TPD_DT_MAX 8'hFF
`define TPD_DT_ZERO 8'h00

// Serial frame: 8-bit command, upper nibble opcode, lower nibble data
`define TPD_CMD_W 8
`define TPD_OP_HI 7
`define TPD_OP_LO 4
`define TPD_OP_NULL 4'h0
`define TPD_OP_FAULT_MASK_FIRST 4'h2
`define TPD_OP_FAULT_MASK_SECOND 4'h3
`define TPD_OP_MODE 4'h4
`define TPD_OP_CLRINT 4'h6
`define TPD_OP_DT_LO 4'h8
`define TPD_OP_DT_HI 4'h9
`define TPD_OP_DT_ZERO 4'hA

// Mode bits: bit 0 defeats interlock, bit 1 defeats deadtime
`define TPD_MODE_NOLOCK 0
`define TPD_MODE_NODT 1
`define TPD_MODE_RST 2'h0

// Reset values
`define TPD_MASK_RST 4'hF
`define TPD_DT_RST 8'h10

`endif

/* core/tpd_sync.v */
// Two flip-flop synchroniser, one per bit of a bus
`timescale 1ns/10ps
module tpd_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      stage_one <= INIT;
      sync_out <= INIT;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // tpd_sync

/* core/tpd_phase.v */
// One phase: deadtime, interlock and low-before-high gating
`timescale 1ns/10ps
`include "tpd_defs.vh"
module tpd_phase #(
  parameter DT_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Commands, already synchronised
  input wire high_req,
  input wire low_req,
  // Configuration
  input wire enabled,
  input wire [DT_W-1:0] deadtime,
  input wire no_interlock,
  input wire no_deadtime,
  // Gate commands before the enable gating
  output reg high_drive,
  output reg low_drive,
  output reg low_seen
);

  reg [DT_W-1:0] dt_count;
  reg next_high;
  reg next_low;

  // Deadtime runs whenever a driver turned off this phase
  wire dt_busy = (dt_count != {DT_W{1'b0}}) && !no_deadtime;
  wire both = high_req && low_req && !no_interlock;

  always @* begin
    next_high = high_req && low_seen && !both && !dt_busy && !low_drive;
    next_low = low_req && !both && !dt_busy && !high_drive;
    if (no_interlock) begin
      next_high = high_req && low_seen && !dt_busy;
      next_low = low_req && !dt_busy;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n || !enabled) begin
      high_drive <= 1'b0;
      low_drive <= 1'b0;
      dt_count <= {DT_W{1'b0}};
      low_seen <= 1'b0;
    end else begin
      high_drive <= next_high;
      low_drive <= next_low;
      if (low_drive)
        low_seen <= 1'b1;
      if ((high_drive && !next_high) || (low_drive && !next_low))
        dt_count <= deadtime;
      else if (dt_count != {DT_W{1'b0}})
        dt_count <= dt_count - {{(DT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // tpd_phase

/* tb/tpd_mcu.sv */
// Controller model driving the serial port of the pre-driver
`timescale 1ns/10ps
module tpd_mcu (
  // Clock
  input wire sys_clk,
  // Serial pins
  output reg serial_cs_n,
  output reg serial_clk,
  output reg serial_in
);
  integer i;
  initial begin
    serial_cs_n = 1'h1;
    serial_clk = 1'h0;
    serial_in = 1'h0;
  end
  //////////////////////////////
  // Clock stands low outside frames; data falls back to its pull-down level
  task send(input [7:0] b);
    begin
      repeat (6) @(posedge sys_clk);
      serial_cs_n <= 1'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        repeat (4) @(posedge sys_clk);
        serial_clk <= 1'h1;
        serial_in <= b[i];
        repeat (4) @(posedge sys_clk);
        serial_clk <= 1'h0;
      end
      repeat (8) @(posedge sys_clk);
      serial_cs_n <= 1'h1;
      serial_in <= 1'h0;
      // Step off the edge so callers never sample in the launching time step
      #1;
    end
  endtask
endmodule // tpd_mcu

/* tb/tpd_core_assertions.sv */
// Port-level checks for the pre-driver logic interface
`timescale 1ns/10ps
module tpd_chk (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  input wire power_good,
  // Enables
  input wire enable_one,
  input wire enable_two,
  // Status inputs
  input wire [2:0] phase_above_half,
  input wire overcurrent_det,
  input wire [7:0] fault_det,
  // Serial port
  input wire serial_cs_n,
  input wire serial_out_en,
  // Outputs
  input wire [2:0] high_side_gate,
  input wire [2:0] low_side_gate,
  input wire gate_drive_en,
  input wire phase_a_compare_out,
  input wire overcurrent_flag_out,
  input wire interrupt_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n || !power_good);
  //////////////////////////////
  // Low-side pulses seen since the drives were last enabled
  reg [2:0] low_ok;
  always @(posedge sys_clk) begin
    if (!(enable_one && enable_two && reset_n && power_good))
      low_ok <= 3'h0;
    else
      low_ok <= low_ok | low_side_gate;
  end
  sequence cs_quiet;
    serial_cs_n [*4];
  endsequence
  sequence oc_steady;
    $stable(overcurrent_det) [*4];
  endsequence
  gate_off_a: assert property (!(enable_one && enable_two) |->
    (high_side_gate | low_side_gate) == 3'h0) else $error("gate on while disabled");
  hi_after_lo_a: assert property ((high_side_gate & ~low_ok) == 3'h0)
    else $error("high side before low pulse");
  drv_tristate_a: assert property (disable iff (!reset_n)
    !power_good |-> !gate_drive_en) else $error("drivers live without power");
  so_idle_a: assert property (serial_cs_n |-> !serial_out_en)
    else $error("serial out driven while idle");
  so_drive_a: assert property (!serial_cs_n |-> serial_out_en)
    else $error("serial out not driven in frame");
  cmp_follow_a: assert property ($stable(phase_above_half[0]) [*4] |->
    phase_a_compare_out == phase_above_half[0]) else $error("phase status wrong");
  oc_follow_a: assert property (oc_steady |-> overcurrent_flag_out == overcurrent_det)
    else $error("overcurrent flag wrong");
  irq_hold_a: assert property (cs_quiet ##0 interrupt_out |=> interrupt_out)
    else $error("interrupt dropped without command");
  irq_cause_a: assert property ($rose(interrupt_out) |->
    ($past(fault_det, 3) | $past(fault_det, 4)) != 8'h00) else $error("interrupt without fault");
  reset_quiet_a: assert property (disable iff (1'h0) !reset_n |->
    (high_side_gate | low_side_gate) == 3'h0 ##1 !(interrupt_out || overcurrent_flag_out))
    else $error("outputs live in reset");
endmodule // tpd_chk
bind tpd_core tpd_chk i_tpd_chk (.*);

/* tb/tpd_core_tb.sv */
// Self-checking bench for the pre-driver logic interface
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tpd_core_tb;
  reg sys_clk = 1'h0;
  reg reset_n = 1'h0;
  reg power_good = 1'h1;
  reg enable_one = 1'h0;
  reg enable_two = 1'h0;
  reg phase_a_high_in_n = 1'h1;
  reg phase_b_high_in_n = 1'h1;
  reg phase_c_high_in_n = 1'h1;
  reg phase_a_low_in = 1'h0;
  reg phase_b_low_in = 1'h0;
  reg phase_c_low_in = 1'h0;
  reg [2:0] phase_above_half = 3'h0;
  reg overcurrent_det = 1'h0;
  reg [7:0] fault_det = 8'h00;
  wire serial_cs_n, serial_clk, serial_in, serial_out, serial_out_en, gate_drive_en;
  wire [2:0] high_side_gate, low_side_gate;
  wire phase_a_compare_out, phase_b_compare_out, phase_c_compare_out;
  wire overcurrent_flag_out, interrupt_out;
  integer bad_count = 0;
  integer checks_done = 0;
  tpd_core i_tpd_core (.*);
  tpd_mcu i_tpd_mcu (.sys_clk(sys_clk), .serial_cs_n(serial_cs_n),
    .serial_clk(serial_clk), .serial_in(serial_in));
  always #20 sys_clk = ~sys_clk;
  //////////////////////////////
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Gates follow three edges after a pin change, sampled one edge later
  task ph(input [2:0] hi, input [2:0] lo);
    begin
      @(posedge sys_clk);
      {phase_c_high_in_n, phase_b_high_in_n, phase_a_high_in_n} <= ~hi;
      {phase_c_low_in, phase_b_low_in, phase_a_low_in} <= lo;
      repeat (4) @(posedge sys_clk);
      #1;
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  initial begin
    #200000;
    bad_count++;
    end_of_test;
  end
  initial begin
    wt(4);
    reset_n <= 1'h1;
    wt(3);
    `CHK({high_side_gate, low_side_gate, interrupt_out}, 7'h00)
    `CHK(serial_out_en, 1'h0)
    enable_one <= 1'h1;
    enable_two <= 1'h1;
    ph(3'h7, 3'h0);
    `CHK(high_side_gate, 3'h0)
    ph(3'h0, 3'h7);
    `CHK(low_side_gate, 3'h7)
    ph(3'h0, 3'h0);
    ph(3'h7, 3'h0);
    `CHK(high_side_gate, 3'h0)
    wt(20);
    `CHK(high_side_gate, 3'h7)
    @(posedge sys_clk);
    enable_two <= 1'h0;
    #1;
    `CHK(high_side_gate, 3'h0)
    wt(4);
    enable_two <= 1'h1;
    wt(5);
    `CHK(high_side_gate, 3'h0)
    ph(3'h0, 3'h7);
    ph(3'h0, 3'h0);
    wt(20);
    ph(3'h7, 3'h7);
    `CHK({high_side_gate, low_side_gate}, 6'h00)
    i_tpd_mcu.send(8'h43);
    `CHK({high_side_gate, low_side_gate}, 6'h3F)
    ph(3'h0, 3'h0);
    phase_above_half <= 3'h5;
    overcurrent_det <= 1'h1;
    wt(5);
    `CHK({phase_c_compare_out, phase_b_compare_out, phase_a_compare_out}, 3'h5)
    `CHK(overcurrent_flag_out, 1'h1)
    fault_det <= 8'h01;
    wt(5);
    `CHK(interrupt_out, 1'h0)
    i_tpd_mcu.send(8'h2E);
    `CHK(interrupt_out, 1'h1)
    i_tpd_mcu.send(8'h60);
    `CHK(interrupt_out, 1'h1)
    `CHK(serial_out, 1'h1)
    fault_det <= 8'h00;
    wt(5);
    `CHK(interrupt_out, 1'h1)
    i_tpd_mcu.send(8'h60);
    `CHK(interrupt_out, 1'h0)
    @(posedge sys_clk);
    power_good <= 1'h0;
    #1;
    `CHK(gate_drive_en, 1'h0)
    wt(2);
    `CHK({high_side_gate, low_side_gate}, 6'h00)
    end_of_test;
  end
endmodule // tpd_core_tb
